// file: rtl/csr_pkg.sv
package csr_pkg;

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  localparam logic [ADDR_W-1:0] ADDR_STATUS = 16'h0FA3;
  localparam logic [ADDR_W-1:0] ADDR_ALARM = 16'h0FA4;
  localparam logic [ADDR_W-1:0] ADDR_ERROR = 16'h0FA5;
  localparam logic [ADDR_W-1:0] ADDR_OUT_LO = 16'h1017;
  localparam logic [ADDR_W-1:0] ADDR_OUT_HI = 16'h1018;
  localparam logic [ADDR_W-1:0] ADDR_VALVE = 16'h1019;
  localparam logic [ADDR_W-1:0] ADDR_FAIL_SEL = 16'h101A;
  localparam logic [ADDR_W-1:0] ADDR_MEAN_CAP = 16'h101B;
  localparam logic [ADDR_W-1:0] ADDR_DEV_MAX = 16'h101C;

  // ------------------------------------------------------------
  // ranges and reset values
  // ------------------------------------------------------------
  localparam logic [DATA_W-1:0] SIGNAL_MAX = 16'h03E8;
  localparam logic [DATA_W-1:0] SIGNAL_HALF = 16'h01F4;
  localparam logic [DATA_W-1:0] SIGNAL_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] CODE_MAX = 16'h0002;
  localparam logic [DATA_W-1:0] DEV_MAX_LIMIT = 16'hFFFF;

  localparam logic [DATA_W-1:0] RST_OUT_LO = 16'h0000;
  localparam logic [DATA_W-1:0] RST_OUT_HI = 16'h03E8;
  localparam logic [DATA_W-1:0] RST_MEAN_CAP = 16'h03E8;
  localparam logic [DATA_W-1:0] RST_DEV_MAX = 16'h000A;
  localparam logic [DATA_W-1:0] RST_MEAN = 16'h0000;

  // ------------------------------------------------------------
  // codes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CSR_VALVE_CLOSE = 2'h0,
    CSR_VALVE_OPEN = 2'h1,
    CSR_VALVE_HOLD = 2'h2
  } csr_valve_e;

  typedef enum logic [1:0] {
    CSR_FAIL_OFF = 2'h0,
    CSR_FAIL_PRESET = 2'h1,
    CSR_FAIL_MEAN = 2'h2
  } csr_fail_e;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int ST_DP_MAIN = 0;
  localparam int ST_DP_AUX = 2;
  localparam int ST_TUNE_FAIL = 4;
  localparam int ST_SOFT = 5;
  localparam int ST_TIMER = 6;
  localparam int ST_MANUAL = 7;
  localparam int ST_TUNE_ACT = 8;
  localparam int ST_GAIN = 9;
  localparam int ST_MAIN_OOR = 13;
  localparam int ST_AUX_OOR = 14;
  localparam int ST_ERR = 15;
  localparam int AL_ALARM = 0;
  localparam int AL_HEATER = 4;
  localparam int AL_SHORT = 5;
  localparam int AL_DIN = 6;
  localparam int AL_DOUT = 8;
  localparam int ER_CAL = 0;
  localparam int ER_CSUM = 15;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam longint CLK_HZ = 20000000;
  localparam longint MEAN_PERIOD_S = 60;
  localparam longint MEAN_PERIOD_CYC = MEAN_PERIOD_S * CLK_HZ;
  localparam int MEAN_SHIFT = 2;

endpackage

// file: rtl/csr_regs.sv
`timescale 1ns/1ps

// How it works
// (RQ1) lower output bound, tenths percent, 0..1000
// (RQ2) upper output bound, tenths percent, 0..1000
// (RQ3) aux fault: close, open or hold valve
// (RQ4) failure output: off, preset or mean
// (RQ5) mean sampled each minute under deviation limit
// (RQ6) mean fallback capped by writable limit
// (RQ7) writable maximum deviation for mean sampling
// (RQ8) on-off failure: preset above half gives full
// (RQ9) status bits 0-3 give point positions
// (RQ10) status bit 4 tune failed, 8 tuning
// (RQ11) status bits 5-7 soft start, timer, manual
// (RQ12) status bits 9-10 active gain set
// (RQ13) status bits 13-15 range and error flags
// (RQ14) alarm bits 0-2, 4, 5 alarm states
// (RQ15) alarm bits 6, 8-10 pins, zero if absent
// (RQ16) error bits 0-3 calibration, 15 checksum
// (RQ17) reserved bits zero, status writes ignored
module csr_regs #(
  parameter longint MEAN_PERIOD = csr_pkg::MEAN_PERIOD_CYC,
  parameter bit HAS_DIG_IN = 1'b1,
  parameter logic [2:0] HAS_DIG_OUT = 3'h7
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // register port
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [csr_pkg::ADDR_W-1:0] addr_i,
  input wire logic [csr_pkg::DATA_W-1:0] wr_data_i,
  output logic [csr_pkg::DATA_W-1:0] rd_data_o,
  output logic ack_o,
  output logic err_o,
  // control path
  input wire logic [csr_pkg::DATA_W-1:0] ctrl_in_i,
  input wire logic [csr_pkg::DATA_W-1:0] deviation_abs_i,
  input wire logic [csr_pkg::DATA_W-1:0] fallback_preset_i,
  input wire logic on_off_mode_i,
  input wire logic sensor_fail_i,
  input wire logic program_stopped_i,
  input wire logic aux_fault_i,
  output logic [csr_pkg::DATA_W-1:0] ctrl_out_o,
  output logic [1:0] valve_cmd_o,
  output logic valve_override_o,
  output logic [csr_pkg::DATA_W-1:0] mean_value_o,
  // status sources
  input wire logic [1:0] linear_input_point_position_i,
  input wire logic [1:0] aux_point_position_i,
  input wire logic tune_failed_i,
  input wire logic soft_start_i,
  input wire logic timer_done_i,
  input wire logic manual_i,
  input wire logic tune_active_i,
  input wire logic [1:0] gain_set_i,
  input wire logic main_oor_i,
  input wire logic aux_oor_i,
  // alarm and error sources
  input wire logic [2:0] alarm_i,
  input wire logic heater_burn_i,
  input wire logic out1_short_i,
  input wire logic dig_in_i,
  input wire logic [2:0] dig_out_i,
  input wire logic [3:0] cal_lost_i,
  input wire logic checksum_err_i
);
  import csr_pkg::*;

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [DATA_W-1:0] output_lower_bound;
  logic [DATA_W-1:0] output_upper_bound;
  logic [1:0] valve_fault_action;
  logic [1:0] failure_output_select;
  logic [DATA_W-1:0] mean_output_cap;
  logic [DATA_W-1:0] mean_sampling_deviation_max;
  logic [DATA_W-1:0] mean_value;
  logic [63:0] minute_cnt;

  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] alarm_word;
  logic [DATA_W-1:0] error_word;
  logic sig_ok;
  logic code_ok;
  logic hit;
  logic [DATA_W-1:0] next_rd;
  logic wr_take;
  logic rd_take;
  logic wr_ro;
  logic sample_tick;
  logic [DATA_W+1:0] mean_sum;

  // ------------------------------------------------------------
  // status words, assembled live
  // ------------------------------------------------------------
  always_comb begin
    error_word = '0; // RQ17
    error_word[ER_CAL +: 4] = cal_lost_i; // RQ16
    error_word[ER_CSUM] = checksum_err_i; // RQ16
  end

  always_comb begin
    status_word = '0; // RQ17
    status_word[ST_DP_MAIN +: 2] = linear_input_point_position_i; // RQ9
    status_word[ST_DP_AUX +: 2] = aux_point_position_i; // RQ9
    status_word[ST_TUNE_FAIL] = tune_failed_i; // RQ10
    status_word[ST_TUNE_ACT] = tune_active_i; // RQ10
    status_word[ST_SOFT] = soft_start_i; // RQ11
    status_word[ST_TIMER] = timer_done_i; // RQ11
    status_word[ST_MANUAL] = manual_i; // RQ11
    status_word[ST_GAIN +: 2] = gain_set_i; // RQ12
    status_word[ST_MAIN_OOR] = main_oor_i; // RQ13
    status_word[ST_AUX_OOR] = aux_oor_i; // RQ13
    status_word[ST_ERR] = |error_word; // RQ13
  end

  always_comb begin
    alarm_word = '0; // RQ17
    alarm_word[AL_ALARM +: 3] = alarm_i; // RQ14
    alarm_word[AL_HEATER] = heater_burn_i; // RQ14
    alarm_word[AL_SHORT] = out1_short_i; // RQ14
    // absent pins read zero so software sees no phantom state
    alarm_word[AL_DIN] = dig_in_i & HAS_DIG_IN; // RQ15
    alarm_word[AL_DOUT +: 3] = dig_out_i & HAS_DIG_OUT; // RQ15
  end

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  assign sig_ok = (wr_data_i <= SIGNAL_MAX);
  assign code_ok = (wr_data_i <= CODE_MAX);

  assign wr_take = ce_i & wr_en_i;
  assign rd_take = ce_i & rd_en_i;
  assign wr_ro = wr_en_i & (addr_i == ADDR_STATUS || addr_i == ADDR_ALARM || addr_i == ADDR_ERROR); // RQ17

  // out-of-range writes are refused whole, the old value stays
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      output_lower_bound <= RST_OUT_LO;
    end else if (wr_take && addr_i == ADDR_OUT_LO && sig_ok) begin
      output_lower_bound <= wr_data_i; // RQ1
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      output_upper_bound <= RST_OUT_HI;
    end else if (wr_take && addr_i == ADDR_OUT_HI && sig_ok) begin
      output_upper_bound <= wr_data_i; // RQ2
    end
  end

  // ------------------------------------------------------------
  // fallback codes and mean settings
  // ------------------------------------------------------------
  // codes above two are refused, not wrapped
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valve_fault_action <= CSR_VALVE_CLOSE;
    end else if (wr_take && addr_i == ADDR_VALVE && code_ok) begin
      valve_fault_action <= wr_data_i[1:0]; // RQ3
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      failure_output_select <= CSR_FAIL_OFF;
    end else if (wr_take && addr_i == ADDR_FAIL_SEL && code_ok) begin
      failure_output_select <= wr_data_i[1:0]; // RQ4
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mean_output_cap <= RST_MEAN_CAP;
    end else if (wr_take && addr_i == ADDR_MEAN_CAP && sig_ok) begin
      mean_output_cap <= wr_data_i; // RQ6
    end
  end

  // a 16-bit word always fits; the compare guards a narrower limit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mean_sampling_deviation_max <= RST_DEV_MAX;
    end else if (wr_take && addr_i == ADDR_DEV_MAX && wr_data_i <= DEV_MAX_LIMIT) begin
      mean_sampling_deviation_max <= wr_data_i; // RQ7
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------

  always_comb begin
    hit = 1'b1;
    next_rd = '0;
    case (addr_i)
      ADDR_STATUS: next_rd = status_word;
      ADDR_ALARM: next_rd = alarm_word;
      ADDR_ERROR: next_rd = error_word;
      ADDR_OUT_LO: next_rd = output_lower_bound;
      ADDR_OUT_HI: next_rd = output_upper_bound;
      ADDR_VALVE: next_rd = {14'h0000, valve_fault_action};
      ADDR_FAIL_SEL: next_rd = {14'h0000, failure_output_select};
      ADDR_MEAN_CAP: next_rd = mean_output_cap;
      ADDR_DEV_MAX: next_rd = mean_sampling_deviation_max;
      default: hit = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // bus answer
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= '0;
    end else if (rd_take) begin
      rd_data_o <= next_rd;
    end
  end

  // ack answers every taken request, mapped or not
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
    end else if (ce_i) begin
      ack_o <= rd_en_i | wr_en_i;
    end
  end

  // err flags unmapped addresses and writes to the read-only words
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_o <= 1'b0;
    end else if (ce_i) begin
      err_o <= (rd_en_i | wr_en_i) & (!hit | wr_ro); // RQ17
    end
  end

  // ------------------------------------------------------------
  // mean value of the output
  // ------------------------------------------------------------
  assign mean_sum = {2'b00, mean_value} * 18'd3 + {2'b00, ctrl_out_o};
  assign sample_tick = (minute_cnt >= 64'(MEAN_PERIOD - 1)); // RQ5

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      minute_cnt <= '0;
    end else if (ce_i && sample_tick) begin
      minute_cnt <= '0;
    end else if (ce_i) begin
      minute_cnt <= minute_cnt + 64'd1;
    end
  end

  // ------------------------------------------------------------
  // running mean
  // ------------------------------------------------------------
  // a first-order average: cheap, no sample memory, slow to settle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mean_value <= RST_MEAN;
    end else if (ce_i && sample_tick && deviation_abs_i < mean_sampling_deviation_max) begin // RQ5
      mean_value <= 16'(mean_sum >> MEAN_SHIFT);
    end
  end

  // ------------------------------------------------------------
  // output selection
  // ------------------------------------------------------------
  logic fail_active;
  logic [DATA_W-1:0] capped_mean;
  logic [DATA_W-1:0] pick;
  logic [DATA_W-1:0] next_out;
  logic clamp_on;

  assign fail_active = sensor_fail_i | program_stopped_i;
  assign capped_mean = (mean_value > mean_output_cap) ? mean_output_cap : mean_value; // RQ6
  assign clamp_on = !(fail_active && (on_off_mode_i || failure_output_select == CSR_FAIL_OFF));

  always_comb begin
    pick = ctrl_in_i;
    if (fail_active) begin
      if (on_off_mode_i) begin
        pick = (fallback_preset_i > SIGNAL_HALF) ? SIGNAL_MAX : SIGNAL_ZERO; // RQ8
      end else begin
        case (failure_output_select) // RQ4
          CSR_FAIL_OFF: pick = SIGNAL_ZERO;
          CSR_FAIL_PRESET: pick = fallback_preset_i;
          CSR_FAIL_MEAN: pick = capped_mean;
          default: pick = SIGNAL_ZERO;
        endcase
      end
    end
    next_out = pick;
    // off and on-off levels bypass the bounds; continuous values obey them
    if (clamp_on) begin
      if (pick < output_lower_bound) next_out = output_lower_bound; // RQ1
      if (pick > output_upper_bound) next_out = output_upper_bound; // RQ2
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  // the clamp sits ahead of this flop, so the pin shows an unclamped value only for the off and on-off fallback levels
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_out_o <= SIGNAL_ZERO;
    end else if (ce_i) begin
      ctrl_out_o <= next_out;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valve_override_o <= 1'b0;
    end else if (ce_i) begin
      valve_override_o <= aux_fault_i; // RQ3
    end
  end

  // hold is the idle command, so a cleared fault leaves the valve alone
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valve_cmd_o <= CSR_VALVE_HOLD;
    end else if (ce_i) begin
      valve_cmd_o <= aux_fault_i ? valve_fault_action : CSR_VALVE_HOLD; // RQ3
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mean_value_o <= RST_MEAN;
    end else if (ce_i) begin
      mean_value_o <= capped_mean;
    end
  end

endmodule

// file: testbench/csr_host.sv
`timescale 1ns/1ps
module csr_host (
  // clock
  input wire logic clk_i,
  // register port
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [15:0] addr_o,
  output logic [15:0] wr_data_o,
  input wire logic [15:0] rd_data_i,
  input wire logic ack_i,
  input wire logic err_i
);
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 16'h0000;
    wr_data_o = 16'h0000;
  end
  // one-cycle request; once released the enables drop and address and data go to inverted junk
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic e, output logic ok);
    @(negedge clk_i);
    wr_en_o = w;
    rd_en_o = !w;
    addr_o = a;
    wr_data_o = d;
    @(negedge clk_i);
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = ~a;
    wr_data_o = ~d;
    q = rd_data_i;
    e = err_i;
    ok = ack_i;
  endtask
endmodule

// file: testbench/csr_regs_props.sv
`timescale 1ns/1ps
module csr_regs_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic ce_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] rd_data_o,
  input wire logic ack_o,
  input wire logic err_o,
  // control path
  input wire logic on_off_mode_i,
  input wire logic sensor_fail_i,
  input wire logic program_stopped_i,
  input wire logic aux_fault_i,
  input wire logic [15:0] fallback_preset_i,
  input wire logic [15:0] ctrl_out_o,
  input wire logic [1:0] valve_cmd_o,
  input wire logic [15:0] mean_value_o,
  // error sources
  input wire logic [3:0] cal_lost_i,
  input wire logic checksum_err_i
);
  import csr_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic rd;
  logic ff;
  // a read beside a write shows the old word, so reads are checked alone
  assign rd = ce_i && rd_en_i && !wr_en_i;
  assign ff = ce_i && on_off_mode_i && (sensor_fail_i || program_stopped_i);
  ro_write_a: assert property (ce_i && wr_en_i && addr_i inside {[ADDR_STATUS:ADDR_ERROR]} |-> ##1 ack_o && err_o)
    else $error("status word write not flagged");
  err_word_a: assert property (rd && addr_i == ADDR_ERROR |=>
    rd_data_o == {$past(checksum_err_i), 11'h000, $past(cal_lost_i)}) else $error("error word wrong");
  stat_flag_a: assert property (rd && addr_i == ADDR_STATUS |=> rd_data_o[12:11] == 2'h0 &&
    rd_data_o[15] == ($past(cal_lost_i) != 4'h0 || $past(checksum_err_i))) else $error("status flags wrong");
  valve_idle_a: assert property ((ce_i && !aux_fault_i) [*2] |=> valve_cmd_o == 2'h2)
    else $error("valve not held without fault");
  onoff_full_a: assert property (ff && fallback_preset_i > SIGNAL_HALF |=> ctrl_out_o == SIGNAL_MAX)
    else $error("on-off fallback not full");
  onoff_zero_a: assert property (ff && fallback_preset_i <= SIGNAL_HALF |=> ctrl_out_o == SIGNAL_ZERO)
    else $error("on-off fallback not zero");
  out_range_a: assert property (ctrl_out_o <= SIGNAL_MAX)
    else $error("control output above full scale");
  mean_cap_a: assert property (mean_value_o <= SIGNAL_MAX)
    else $error("mean above full scale");
  cover property (ack_o && err_o);
  cover property (ctrl_out_o == SIGNAL_MAX);
  cover property ($changed(mean_value_o));
endmodule

bind csr_regs csr_regs_props u_csr_regs_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
  .addr_i(addr_i), .rd_data_o(rd_data_o), .ack_o(ack_o), .err_o(err_o), .on_off_mode_i(on_off_mode_i),
  .sensor_fail_i(sensor_fail_i), .program_stopped_i(program_stopped_i), .aux_fault_i(aux_fault_i),
  .fallback_preset_i(fallback_preset_i), .ctrl_out_o(ctrl_out_o), .valve_cmd_o(valve_cmd_o),
  .mean_value_o(mean_value_o), .cal_lost_i(cal_lost_i), .checksum_err_i(checksum_err_i)
);

// file: testbench/csr_regs_tb_top.sv
`timescale 1ns/1ps
module csr_regs_tb_top;
  import csr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wr_en, rd_en, ack, err, e, ok;
  logic onoff = 1'b0, sfail = 1'b0, pstop = 1'b0, aux = 1'b0;
  logic [15:0] addr, wdata, rdata, ctrl_out, mean, q;
  logic [15:0] ctrl_in = 16'h0000, preset = 16'h0000, dev = 16'hFFFF;
  logic [1:0] valve;
  logic ovr;
  logic ce = 1'b1;
  logic [26:0] src = 27'h0;
  int n_fail = 0;
  int comparisons = 0;
  // address, write data, read back, write error, read error
  localparam logic [49:0] ROWS [14] = '{
    {16'h1017, 16'h03E9, 16'h0000, 2'h0}, {16'h1017, 16'h03E8, 16'h03E8, 2'h0},
    {16'h1017, 16'h0064, 16'h0064, 2'h0}, {16'h1018, 16'h03E9, 16'h03E8, 2'h0},
    {16'h1018, 16'h0258, 16'h0258, 2'h0}, {16'h1019, 16'h0003, 16'h0000, 2'h0},
    {16'h1019, 16'h0002, 16'h0002, 2'h0}, {16'h101A, 16'h0003, 16'h0000, 2'h0},
    {16'h101B, 16'h03E9, 16'h03E8, 2'h0}, {16'h101B, 16'h0320, 16'h0320, 2'h0},
    {16'h101C, 16'hFFFF, 16'hFFFF, 2'h0}, {16'h101C, 16'h000A, 16'h000A, 2'h0},
    {16'h0FA3, 16'h1234, 16'h0000, 2'h2}, {16'h0FA6, 16'h0000, 16'h0000, 2'h3}};
  always #25 clk_i = ~clk_i;
  csr_host u_csr_host (.clk_i(clk_i), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr), .wr_data_o(wdata),
    .rd_data_i(rdata), .ack_i(ack), .err_i(err));
  csr_regs #(.MEAN_PERIOD(16)) u_csr_regs (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .wr_en_i(wr_en),
    .rd_en_i(rd_en), .addr_i(addr), .wr_data_i(wdata), .rd_data_o(rdata), .ack_o(ack), .err_o(err),
    .ctrl_in_i(ctrl_in), .deviation_abs_i(dev), .fallback_preset_i(preset), .on_off_mode_i(onoff),
    .sensor_fail_i(sfail), .program_stopped_i(pstop), .aux_fault_i(aux), .ctrl_out_o(ctrl_out),
    .valve_cmd_o(valve), .valve_override_o(ovr), .mean_value_o(mean), .linear_input_point_position_i(src[1:0]),
    .aux_point_position_i(src[3:2]), .tune_failed_i(src[4]), .soft_start_i(src[5]), .timer_done_i(src[6]),
    .manual_i(src[7]), .tune_active_i(src[8]), .gain_set_i(src[10:9]), .main_oor_i(src[11]),
    .aux_oor_i(src[12]), .alarm_i(src[15:13]), .heater_burn_i(src[16]), .out1_short_i(src[17]),
    .dig_in_i(src[18]), .dig_out_i(src[21:19]), .cal_lost_i(src[25:22]), .checksum_err_i(src[26]));
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rw(input logic w, input logic [15:0] a, input logic [15:0] d);
    u_csr_host.xfer(w, a, d, q, e, ok);
  endtask
  task automatic drive(input logic [15:0] ci, input logic [15:0] pr, input logic [3:0] m, input logic [17:0] x);
    @(negedge clk_i);
    ctrl_in = ci;
    preset = pr;
    {onoff, sfail, pstop, aux} = m;
    repeat (3) @(negedge clk_i);
    chk({valve, ctrl_out}, x);
    chk({17'h0, ovr}, {17'h0, m[0]});
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // watchdog: tests take about 1400 cycles, sevenfold margin
  // ------------------------------------------------------------
  initial begin
    repeat (10000) @(posedge clk_i);
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'b1;
    for (int i = 0; i < 14; i++) begin
      rw(1'b1, ROWS[i][49:34], ROWS[i][33:18]);
      chk({ok, e, 16'h0000}, {1'b1, ROWS[i][1], 16'h0000});
      rw(1'b0, ROWS[i][49:34], 16'h0000);
      chk({ok, e, q}, {1'b1, ROWS[i][0], ROWS[i][17:2]});
    end
    for (int j = 0; j < 2; j++) begin
      src = (j == 0) ? 27'h5555555 : 27'h2AAAAAA;
      rw(1'b0, ADDR_STATUS, 16'h0000);
      chk({ok, e, q}, {2'h2, |src[26:22], src[12:11], 2'h0, src[10:0]});
      rw(1'b0, ADDR_ALARM, 16'h0000);
      chk({ok, e, q}, {7'h40, src[21:19], 1'b0, src[18:16], 1'b0, src[15:13]});
      rw(1'b0, ADDR_ERROR, 16'h0000);
      chk({ok, e, q}, {2'h2, src[26], 11'h000, src[25:22]});
    end
    src = 27'h0;
    drive(16'h02BC, 16'h0000, 4'h0, {2'h2, 16'h0258});
    drive(16'h0032, 16'h0000, 4'h0, {2'h2, 16'h0064});
    drive(16'h0032, 16'h01F5, 4'hC, {2'h2, 16'h03E8});
    drive(16'h0032, 16'h01F4, 4'hA, {2'h2, 16'h0000});
    for (int v = 0; v < 3; v++) begin
      rw(1'b1, ADDR_VALVE, 16'(v));
      drive(16'h0190, 16'h0000, 4'h1, {2'(v), 16'h0190});
    end
    drive(16'h0190, 16'h0000, 4'h0, {2'h2, 16'h0190});
    dev = 16'h000A;
    repeat (640) @(negedge clk_i);
    chk({2'h0, mean}, 18'h00000);
    dev = 16'h0009;
    repeat (640) @(negedge clk_i);
    chk({2'h0, mean}, 18'h0018D);
    rw(1'b1, ADDR_MEAN_CAP, 16'h012C);
    dev = 16'hFFFF;
    repeat (2) @(negedge clk_i);
    chk({2'h0, mean}, 18'h0012C);
    for (int s = 0; s < 3; s++) begin
      rw(1'b1, ADDR_FAIL_SEL, 16'(s));
      drive(16'h0190, 16'h00FA, 4'h4, {2'h2, (s == 0) ? 16'h0000 : (s == 1) ? 16'h00FA : 16'h012C});
    end
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk({valve, ctrl_out}, {2'h2, 16'h0000});
    rst_n_i = 1'b1;
    rw(1'b0, ADDR_OUT_HI, 16'h0000);
    chk({ok, e, q}, {2'h2, RST_OUT_HI});
    @(negedge clk_i);
    ce = 1'b0;
    rw(1'b1, ADDR_OUT_HI, 16'h0064);
    chk({ok, e, 16'h0000}, 18'h00000);
    ce = 1'b1;
    rw(1'b0, ADDR_OUT_HI, 16'h0000);
    chk({ok, e, q}, {2'h2, RST_OUT_HI});
    print_verdict();
  end
endmodule
